/* File: design/buc_counter.sv */
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module buc_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_clock,
    input wire logic mode_select_one,
    input wire logic mode_select_zero,
    input wire logic count_enable_n,
    input wire logic output_enable_n,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic [7:0] io_oe,
    output logic terminal_count_n
);
    // register state
    buc_pkg::buc_ctrl_type ctrl, next_ctrl; // software control set
    logic [7:0] load_val, next_load_val; // software load value
    logic [7:0] count, next_count; // the counter itself
    logic clk_prev, next_clk_prev; // last sample of count_clock
    logic [31:0] next_prdata; // read word taken at setup
    logic next_pslverr; // error flag taken at setup
    // decode helpers
    buc_pkg::buc_ctrl_type eff; // control set actually in force
    buc_pkg::buc_op_type op; // operation for the next edge
    logic setup_ph, access_wr, tick, addr_ok;
    logic [7:0] load_src;

    // apb phases: answer always one cycle after setup
    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign pready = psel & penable;
    assign addr_ok = (paddr == buc_pkg::OFS_CTRL) | (paddr == buc_pkg::OFS_LOAD) |
                     (paddr == buc_pkg::OFS_STEP) | (paddr == buc_pkg::OFS_STATUS);

    // control source: pins, or registers when software takes over
    always_comb begin
        if (ctrl.src_sw) begin
            eff = ctrl;
            load_src = load_val;
        end else begin
            eff.src_sw = 1'b0;
            eff.mode_select_one = mode_select_one;
            eff.mode_select_zero = mode_select_zero;
            eff.count_enable_n = count_enable_n;
            eff.output_enable_n = output_enable_n;
            load_src = io_in;
        end
    end

    // counting edge: rising count_clock on pins, step write in software mode
    // count_clock is synchronous to pclk, so no synchroniser in front of it
    assign tick = ctrl.src_sw ? (access_wr & (paddr == buc_pkg::OFS_STEP))
                              : (count_clock & ~clk_prev);

    // operation decode from the two selects and both enables
    always_comb begin
        unique case ({eff.mode_select_one, eff.mode_select_zero})
            2'b00: op = eff.output_enable_n ? buc_pkg::BUC_LOAD : buc_pkg::BUC_HOLD;
            2'b11: op = buc_pkg::BUC_HOLD;
            2'b10: op = eff.count_enable_n ? buc_pkg::BUC_HOLD : buc_pkg::BUC_UP;
            2'b01: op = eff.count_enable_n ? buc_pkg::BUC_HOLD : buc_pkg::BUC_DOWN;
        endcase
    end

    // next count; plain 8-bit arithmetic gives the wrap
    always_comb begin
        next_count = count;
        next_clk_prev = count_clock;
        if (tick) begin
            unique case (op)
                buc_pkg::BUC_UP: next_count = count + buc_pkg::CNT_ONE;
                buc_pkg::BUC_DOWN: next_count = count - buc_pkg::CNT_ONE;
                buc_pkg::BUC_LOAD: next_count = load_src;
                buc_pkg::BUC_HOLD: next_count = count;
                default: next_count = count;
            endcase
        end
    end

    // count and edge-detect flops only register the next values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= buc_pkg::CNT_RESET;
            clk_prev <= 1'b0;
        end else begin
            count <= next_count;
            clk_prev <= next_clk_prev;
        end
    end

    // terminal count: combinational on the enable for look-ahead cascading
    // decoded, so it may glitch; downstream must not clock on it
    always_comb begin
        terminal_count_n = 1'b1;
        if (!eff.count_enable_n) begin
            if (op == buc_pkg::BUC_UP && count == buc_pkg::CNT_ONES)
                terminal_count_n = 1'b0;
            if (op == buc_pkg::BUC_DOWN && count == buc_pkg::CNT_ZEROS)
                terminal_count_n = 1'b0;
        end
    end

    // shared data lines: value from the flops, enable from output enable
    assign io_out = count;
    assign io_oe = eff.output_enable_n ? 8'h00 : 8'hFF;

    // register writes take effect at the access edge
    always_comb begin
        next_ctrl = ctrl;
        next_load_val = load_val;
        if (access_wr && paddr == buc_pkg::OFS_CTRL) begin
            next_ctrl.output_enable_n = pwdata[buc_pkg::CTRL_OE_N_BIT];
            next_ctrl.count_enable_n = pwdata[buc_pkg::CTRL_CE_N_BIT];
            next_ctrl.mode_select_zero = pwdata[buc_pkg::CTRL_S0_BIT];
            next_ctrl.mode_select_one = pwdata[buc_pkg::CTRL_S1_BIT];
            next_ctrl.src_sw = pwdata[buc_pkg::CTRL_SRC_BIT];
        end
        if (access_wr && paddr == buc_pkg::OFS_LOAD)
            next_load_val = pwdata[7:0];
    end

    // read data and error captured in the setup cycle
    always_comb begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup_ph) begin
            next_pslverr = ~addr_ok;
            next_prdata = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    buc_pkg::OFS_CTRL: next_prdata = {27'h0000000, ctrl};
                    buc_pkg::OFS_LOAD: next_prdata = {24'h000000, load_val};
                    buc_pkg::OFS_STATUS:
                        next_prdata = {18'h00000, eff, terminal_count_n, count};
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // register file flops; reset hands control back to the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= buc_pkg::CTRL_RESET;
            load_val <= buc_pkg::LOAD_RESET;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            load_val <= next_load_val;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // checks beside the logic
    // one step up per counting edge
    property p_up;
        @(posedge pclk) disable iff (!presetn)
        (tick && op == buc_pkg::BUC_UP) |=> count == $past(count) + 8'h01;
    endproperty
    a_up: assert property (p_up) else $error("count up wrong");

    // one step down per counting edge
    property p_down;
        @(posedge pclk) disable iff (!presetn)
        (tick && op == buc_pkg::BUC_DOWN) |=> count == $past(count) - 8'h01;
    endproperty
    a_down: assert property (p_down) else $error("count down wrong");

    // parallel load takes the selected source
    property p_load;
        @(posedge pclk) disable iff (!presetn)
        (tick && !eff.mode_select_one && !eff.mode_select_zero && eff.output_enable_n)
        |=> count == $past(load_src);
    endproperty
    a_load: assert property (p_load) else $error("parallel load wrong");

    // both selects high freeze the count
    property p_hold_both_high;
        @(posedge pclk) disable iff (!presetn)
        (eff.mode_select_one && eff.mode_select_zero) |=> $stable(count);
    endproperty
    a_hold_both_high: assert property (p_hold_both_high) else $error("hold moved");

    // enable high with a select high: terminal count high, count frozen
    property p_enable_high;
        @(posedge pclk) disable iff (!presetn)
        (eff.count_enable_n && (eff.mode_select_one || eff.mode_select_zero))
        |-> terminal_count_n ##1 $stable(count);
    endproperty
    a_enable_high: assert property (p_enable_high) else $error("enable high failed");

    // no counting edge, no change
    property p_no_tick;
        @(posedge pclk) disable iff (!presetn)
        !tick |=> $stable(count);
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("count moved without edge");

    // output enable high floats every line
    property p_float;
        @(posedge pclk) disable iff (!presetn)
        eff.output_enable_n |-> io_oe == 8'h00;
    endproperty
    a_float: assert property (p_float) else $error("lines driven while disabled");

    // output enable low drives the flops out
    property p_drive;
        @(posedge pclk) disable iff (!presetn)
        !eff.output_enable_n |-> (io_oe == 8'hFF && io_out == count);
    endproperty
    a_drive: assert property (p_drive) else $error("lines not driving count");

    // terminal count at the top when counting up
    property p_tc_up;
        @(posedge pclk) disable iff (!presetn)
        (!eff.count_enable_n && op == buc_pkg::BUC_UP && count == 8'hFF) |-> !terminal_count_n;
    endproperty
    a_tc_up: assert property (p_tc_up) else $error("terminal count missed");

    // up from all ones wraps to zero
    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (tick && op == buc_pkg::BUC_UP && count == 8'hFF) |=> count == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap wrong");

    // down from zero wraps to all ones
    property p_down_wrap;
        @(posedge pclk) disable iff (!presetn)
        (tick && op == buc_pkg::BUC_DOWN && count == buc_pkg::CNT_ZEROS)
        |=> count == buc_pkg::CNT_ONES;
    endproperty
    a_down_wrap: assert property (p_down_wrap) else $error("down wrap wrong");

    // terminal count at zero when counting down
    property p_tc_down;
        @(posedge pclk) disable iff (!presetn)
        (!eff.count_enable_n && op == buc_pkg::BUC_DOWN && count == buc_pkg::CNT_ZEROS)
        |-> !terminal_count_n;
    endproperty
    a_tc_down: assert property (p_tc_down) else $error("terminal count missed down");

    // terminal output low only at a real terminal count
    property p_tc_only;
        @(posedge pclk) disable iff (!presetn)
        !terminal_count_n |-> (!eff.count_enable_n &&
            ((op == buc_pkg::BUC_UP && count == buc_pkg::CNT_ONES) ||
             (op == buc_pkg::BUC_DOWN && count == buc_pkg::CNT_ZEROS)));
    endproperty
    a_tc_only: assert property (p_tc_only) else $error("terminal count low too often");

    // load decoded only from both selects low with lines floating
    property p_op_load;
        @(posedge pclk) disable iff (!presetn)
        (op == buc_pkg::BUC_LOAD) |->
            (!eff.mode_select_one && !eff.mode_select_zero && eff.output_enable_n);
    endproperty
    a_op_load: assert property (p_op_load) else $error("load decoded wrongly");

    // both selects low while driving is a hold, not a load
    property p_low_oe_hold;
        @(posedge pclk) disable iff (!presetn)
        (tick && !eff.mode_select_one && !eff.mode_select_zero && !eff.output_enable_n)
        |=> $stable(count);
    endproperty
    a_low_oe_hold: assert property (p_low_oe_hold) else $error("load while driving");

    // enable high always keeps terminal count high
    property p_ce_tc_high;
        @(posedge pclk) disable iff (!presetn)
        eff.count_enable_n |-> terminal_count_n;
    endproperty
    a_ce_tc_high: assert property (p_ce_tc_high) else $error("tc low while disabled");

    // all eight lines switch together
    property p_lines_together;
        @(posedge pclk) disable iff (!presetn)
        (io_oe == 8'h00) || (io_oe == 8'hFF);
    endproperty
    a_lines_together: assert property (p_lines_together) else $error("lines split");

    // software load takes the load register
    property p_sw_load;
        @(posedge pclk) disable iff (!presetn)
        (tick && ctrl.src_sw && op == buc_pkg::BUC_LOAD) |=> count == $past(load_val);
    endproperty
    a_sw_load: assert property (p_sw_load) else $error("software load wrong");

    // under software control only a bus write can make an edge
    property p_sw_pins_ignored;
        @(posedge pclk) disable iff (!presetn)
        (ctrl.src_sw && !access_wr) |-> !tick;
    endproperty
    a_sw_pins_ignored: assert property (p_sw_pins_ignored) else $error("pin edge in sw mode");

    // up only from selects one-zero with the enable low
    property p_up_decode;
        @(posedge pclk) disable iff (!presetn)
        (op == buc_pkg::BUC_UP) |->
            (eff.mode_select_one && !eff.mode_select_zero && !eff.count_enable_n);
    endproperty
    a_up_decode: assert property (p_up_decode) else $error("up decoded wrongly");

    // down only from selects zero-one with the enable low
    property p_down_decode;
        @(posedge pclk) disable iff (!presetn)
        (op == buc_pkg::BUC_DOWN) |->
            (!eff.mode_select_one && eff.mode_select_zero && !eff.count_enable_n);
    endproperty
    a_down_decode: assert property (p_down_decode) else $error("down decoded wrongly");
endmodule // buc_counter

/* File: design/buc_pkg.sv */
// Summary of operation
// - eight-bit count changes only on clock edge
// - two selects plus both enables choose operation
// - enable low: 10 counts up, 01 down
// - both selects high always hold count
// - selects low, output enable high: load
// - enable high: hold unless selects low with output enable high, terminal count high
// - output enable high floats data lines
// - output enable low drives count out
// - terminal count follows enable combinationally
// - terminal count output is active low
package buc_pkg;
    // counter geometry
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_ONES = 8'hFF;
    localparam logic [7:0] CNT_ZEROS = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // apb map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_LOAD = 12'h004;
    localparam logic [11:0] OFS_STEP = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;

    // control register field positions
    localparam int CTRL_OE_N_BIT = 0;
    localparam int CTRL_CE_N_BIT = 1;
    localparam int CTRL_S0_BIT = 2;
    localparam int CTRL_S1_BIT = 3;
    localparam int CTRL_SRC_BIT = 4;
    // status register field positions
    localparam int STAT_TC_BIT = 8;
    localparam int STAT_CTRL_LSB = 9;

    // reset values: pin control, outputs floating, counting disabled
    localparam logic [4:0] CTRL_RESET = 5'h03;
    localparam logic [7:0] LOAD_RESET = 8'h00;

    // control set that steers one clock edge
    typedef struct packed {
        logic src_sw;
        logic mode_select_one;
        logic mode_select_zero;
        logic count_enable_n;
        logic output_enable_n;
    } buc_ctrl_type;

    // decoded operation for one edge
    typedef enum logic [2:0] {
        BUC_HOLD,
        BUC_UP,
        BUC_DOWN,
        BUC_LOAD
    } buc_op_type;
endpackage

/* File: verification/buc_bus_peer.sv */
`timescale 1ns/1ps
// controller side of the shared data lines; sees both parties' enables
module buc_bus_peer (
    input wire logic pclk,
    input wire logic drive_en,
    input wire logic [7:0] drive_val,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe,
    output logic [7:0] io_in
);
    logic [7:0] last_val = 8'h00; // last resolved level, no pull on the lines
    // resolve each line; undriven lines flip every cycle so a stale value never reads as valid
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (io_oe[i]) begin
                io_in[i] = io_out[i];
            end else if (drive_en) begin
                io_in[i] = drive_val[i];
            end else begin
                io_in[i] = ~last_val[i];
            end
        end
    end
    // terminal count is never taken here, so it can never clock this side
    always_ff @(posedge pclk) begin
        last_val <= io_in;
    end
endmodule // buc_bus_peer

/* File: verification/tb_bidir_updown_counter_8bit.sv */
`timescale 1ns/1ps
module tb_bidir_updown_counter_8bit;
    typedef struct packed {
        logic [1:0] sel; // {one, zero}
        logic ce_n;
        logic oe_n;
        logic [7:0] start;
        logic [7:0] expv;
        logic tc_n; // before the edge
    } buc_row_type;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic count_clock, mode_select_one, mode_select_zero, count_enable_n, output_enable_n;
    logic [7:0] io_in, io_out, io_oe, drive_val;
    logic terminal_count_n, drive_en, err;
    int miscompares = 0;
    int checks_done = 0;
    // ordinary pin cases, one clock edge each
    buc_row_type rows [9] = '{
        '{2'b10, 1'b0, 1'b1, 8'h41, 8'h42, 1'b1}, // up
        '{2'b01, 1'b0, 1'b1, 8'h41, 8'h40, 1'b1}, // down
        '{2'b10, 1'b0, 1'b1, 8'hFF, 8'h00, 1'b0}, // up through the top
        '{2'b01, 1'b0, 1'b0, 8'h00, 8'hFF, 1'b0}, // down through zero
        '{2'b11, 1'b0, 1'b0, 8'h33, 8'h33, 1'b1}, // both high, driving
        '{2'b11, 1'b1, 1'b1, 8'h34, 8'h34, 1'b1}, // both high, disabled
        '{2'b10, 1'b1, 1'b1, 8'hFF, 8'hFF, 1'b1}, // disabled at the top
        '{2'b01, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1}, // disabled at zero
        '{2'b00, 1'b0, 1'b0, 8'h77, 8'h77, 1'b1}  // load pattern while driving: hold
    };
    buc_counter buc_counter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_clock(count_clock),
        .mode_select_one(mode_select_one), .mode_select_zero(mode_select_zero),
        .count_enable_n(count_enable_n), .output_enable_n(output_enable_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .terminal_count_n(terminal_count_n));
    buc_bus_peer buc_bus_peer_inst (.pclk(pclk), .drive_en(drive_en), .drive_val(drive_val),
        .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
    // 20 MHz clock
    always #25 pclk = ~pclk;
    task automatic end_sim;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // pin-side compare: eight lines, or one pin widened by the caller
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(0, 1, "apb hang");
            end_sim();
        end else begin
            // answer taken at the edge where pready was seen high
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // pins change on an edge, then settle until the falling edge
    task automatic set_pins(input logic [1:0] s, input logic ce, input logic oe);
        @(posedge pclk);
        {mode_select_one, mode_select_zero} <= s;
        count_enable_n <= ce;
        output_enable_n <= oe;
        @(negedge pclk);
    endtask
    // one low-high-low pulse on the counter clock pin
    task automatic tick;
        @(posedge pclk) count_clock <= 1'b1;
        @(posedge pclk) count_clock <= 1'b0;
        @(posedge pclk);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        chk(0, 1, "run hung");
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, count_clock, drive_en} = '0;
        {paddr, pwdata, drive_val} = '0;
        {mode_select_one, mode_select_zero, count_enable_n, output_enable_n} = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_pin(io_out, buc_pkg::CNT_RESET, "reset count");
        foreach (rows[i]) begin
            // lines float first, then the controller drives them: no fight
            set_pins(2'b00, rows[i].ce_n, 1'b1);
            @(posedge pclk);
            drive_val <= rows[i].start;
            drive_en <= 1'b1;
            tick();
            drive_en <= 1'b0;
            chk_pin(io_out, rows[i].start, "load");
            set_pins(rows[i].sel, rows[i].ce_n, rows[i].oe_n);
            chk_pin({7'h00, terminal_count_n}, {7'h00, rows[i].tc_n}, "tc");
            chk_pin(io_oe, rows[i].oe_n ? 8'h00 : 8'hFF, "oe");
            tick();
            chk_pin(io_out, rows[i].expv, "count");
        end
        // a pin held high is one edge, not many
        set_pins(2'b10, 1'b0, 1'b1);
        @(posedge pclk) count_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        count_clock <= 1'b0;
        chk_pin(io_out, 8'h78, "level");
        // register side: reset value, unmapped place, software load and step
        apb(1'b0, buc_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h00000003, "ctrl reset");
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1, "unmapped err");
        apb(1'b1, buc_pkg::OFS_LOAD, 32'h5A);
        apb(1'b1, buc_pkg::OFS_CTRL, 32'h13);
        apb(1'b1, buc_pkg::OFS_STEP, 32'h0);
        apb(1'b0, buc_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h0000275A, "sw load");
        apb(1'b1, buc_pkg::OFS_CTRL, 32'h19);
        apb(1'b1, buc_pkg::OFS_STEP, 32'h0);
        apb(1'b0, buc_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h0000335B, "sw up");
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
        // software down step from the last count
        apb(1'b1, buc_pkg::OFS_CTRL, 32'h15);
        apb(1'b1, buc_pkg::OFS_STEP, 32'h0);
        apb(1'b0, buc_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h00002B5A, "sw down");
        // mid-run reset: count clears and the pins take control again
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        chk_pin(io_out, buc_pkg::CNT_RESET, "mid reset count");
        apb(1'b0, buc_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h00000003, "mid reset ctrl");
        end_sim();
    end
endmodule // tb_bidir_updown_counter_8bit
